// *** core_sfr_cfg.svh ***
// Address map, field positions, reset values and masks of the core special registers
`ifndef CORE_SFR_CFG_SVH
`define CORE_SFR_CFG_SVH
`define ADDR_INDIRECT 8'h00
`define ADDR_TIMER 8'h01
`define ADDR_PC 8'h02
`define ADDR_STATUS 8'h03
`define ADDR_BANKPTR 8'h04
`define ADDR_PORT5 8'h05
`define ADDR_PORT6 8'h06
`define ADDR_COMMON_LO 8'h10
`define ADDR_COMMON_HI 8'h1F
`define ADDR_BANKED_LO 8'h20
`define ADDR_BANKED_HI 8'h3F
`define PC_RESET 12'h000
`define STATUS_RESET 8'h18
`define STATUS_MASK 8'h7F
`define PORT5_MASK 8'hF1
`define PORT5_PAGE_BIT 0
`define ST_PAGE_HI 6
`define ST_PAGE_LO 5
`define ST_TIMEOUT 4
`define ST_PWRDN 3
`define ST_ZERO 2
`define ST_HALF 1
`define ST_CARRY 0
`define BANK_HI 7
`define BANK_LO 6
`define STACK_DEPTH 8
`define ZERO8 8'h00
`endif

// *** core_sfr_pkg.sv ***
// Types shared by the core special register group
package core_sfr_pkg;
  // Operations the instruction decoder issues to this group
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_WRITE = 4'b0001,
    OP_JUMP = 4'b0010,
    OP_CALL = 4'b0011,
    OP_RET = 4'b0100,
    OP_STEP = 4'b0101,
    OP_ADDPC = 4'b0110,
    OP_SLEEP = 4'b0111,
    OP_WDCLR = 4'b1000,
    OP_BANK = 4'b1001,
    OP_PAGE = 4'b1010
  } sfr_op_t;
  // One request from the instruction stream
  typedef struct packed {
    sfr_op_t op;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [9:0] target;
    logic [1:0] sel;
    logic flags_we;
    logic [2:0] flags;
  } sfr_req_t;
  // Wake/reset cause presented with a one-cycle strobe
  typedef enum logic [1:0] {
    EV_WDT_WAKE = 2'b00,
    EV_WDT_RUN = 2'b01,
    EV_PIN_WAKE = 2'b10,
    EV_PIN_RESET = 2'b11
  } sfr_event_t;
endpackage

// *** core_sfr.sv ***
// Special-function register group: indirect window, timer, program counter, status, ports
//
// Contract
// - Address zero accesses location named by pointer
// - Timer counts pin edge or cycle, RW
// - Program counter spans 4K word ROM
// - Reset clears whole program counter
// - Jump loads low ten counter bits
// - Call pushes next address, loads low ten
// - Returns reload counter from stack, page kept
// - Add to counter carries into upper bits
// - Move to counter replaces low eight bits
// - Jump, call and move load top bits from page
// - Page select picks one of four pages
// - Timeout flag set by sleep, clear, power
// - Power-down flag set power/clear, cleared sleep
// - Wake and reset causes give flag pairs
// - Status low bits are zero, half, carry
// - Pointer top bits pick data bank
// - Pointer low bits address sixty-four locations
// - Port five upper nibble is data
// - Port five bit zero picks control page
// - Port six holds eight data bits
// - Common bytes plus four banked regions
`timescale 1ns/1ns
`include "core_sfr_cfg.svh"
module core_sfr
  import core_sfr_pkg::*;
(
  input wire logic CLK, // Core clock
  input wire logic RSTN, // Asynchronous reset, active low
  input wire sfr_req_t REQ, // Instruction-stream request
  input wire logic TIMER_PIN, // External timer input pin
  input wire logic TIMER_SRC_PIN, // Timer source: 1 pin edge, 0 cycle
  input wire logic CYCLE_EN, // Instruction cycle enable pulse
  input wire logic EVENT_STB, // Wake/reset cause strobe
  input wire sfr_event_t EVENT_KIND, // Cause presented with strobe
  input wire logic [3:0] PORT5_IN, // Port 5 pin levels
  input wire logic [7:0] PORT6_IN, // Port 6 pin levels
  input wire logic [3:0] PORT5_DIR, // Port 5 direction, 1 input
  input wire logic [7:0] PORT6_DIR, // Port 6 direction, 1 input
  output logic [7:0] RDATA, // Read data for REQ.addr
  output logic [11:0] PC_OUT, // Program ROM address
  output logic [7:0] STATUS_OUT, // Status register copy
  output logic [1:0] BANK_OUT, // Active data bank
  output logic CTRL_PAGE, // Control register page select
  output logic [3:0] PORT5_OUT, // Port 5 output latch
  output logic [7:0] PORT6_OUT // Port 6 output latch
);
  // Architectural state
  logic [7:0] timer_reg, timer_next; // Timer clock counter
  logic [11:0] pc_reg, pc_next; // Program counter
  logic [7:0] status_reg, status_next; // Status and page bits
  logic [7:0] bptr_reg, bptr_next; // Bank and indirect pointer
  logic [7:0] port5_reg, port5_next; // Port 5 latch and page bit
  logic [7:0] port6_reg, port6_next; // Port 6 latch
  logic [7:0] common_mem [16]; // Unbanked general bytes
  logic [7:0] banked_mem [128]; // Four banks of 32 bytes
  logic [11:0] stack_mem [`STACK_DEPTH]; // Return stack
  logic [2:0] sp_reg; // Stack pointer
  logic [7:0] rdata_reg; // Registered read data
  logic pin_s1, pin_s2, pin_s3; // Timer pin synchroniser and edge history
  // Decoded request
  wire [7:0] eff_addr; // Address after indirection
  wire is_wr; // Register write
  wire [1:0] bank_sel; // Current bank
  wire [11:0] pc_inc; // Next sequential address
  wire [11:0] pc_page_base; // Page bits on top
  wire [11:0] stack_top; // Return target
  wire pin_edge; // Synchronised rising edge
  wire timer_tick; // Timer count enable
  wire [6:0] bank_index; // Banked memory index
  wire in_common; // Common region hit
  wire in_banked; // Banked region hit
  logic [7:0] rd_mux; // Combinational read value
  // Address zero has no storage: use the pointer's low six bits
  assign eff_addr = (REQ.addr == `ADDR_INDIRECT) ? {2'b00, bptr_reg[5:0]} : REQ.addr;
  assign is_wr = (REQ.op == OP_WRITE);
  assign bank_sel = bptr_reg[`BANK_HI:`BANK_LO];
  assign pc_inc = pc_reg + 12'h001;
  assign pc_page_base = {status_reg[`ST_PAGE_HI:`ST_PAGE_LO], 10'h000};
  assign stack_top = stack_mem[sp_reg - 3'd1];
  assign pin_edge = pin_s2 & ~pin_s3;
  assign timer_tick = TIMER_SRC_PIN ? pin_edge : CYCLE_EN;
  assign bank_index = {bank_sel, eff_addr[4:0]};
  assign in_common = (eff_addr >= `ADDR_COMMON_LO) && (eff_addr <= `ADDR_COMMON_HI);
  assign in_banked = (eff_addr >= `ADDR_BANKED_LO) && (eff_addr <= `ADDR_BANKED_HI);

  // Read multiplexer; unused bits read zero
  always_comb
  begin
    rd_mux = `ZERO8;
    case (eff_addr)
      `ADDR_TIMER: rd_mux = timer_reg;
      `ADDR_PC: rd_mux = pc_reg[7:0];
      `ADDR_STATUS: rd_mux = status_reg & `STATUS_MASK;
      `ADDR_BANKPTR: rd_mux = bptr_reg;
      // Inputs show pin level, outputs show the latch
      `ADDR_PORT5: rd_mux = {(PORT5_DIR & PORT5_IN) | (~PORT5_DIR & port5_reg[7:4]), 3'b000,
        port5_reg[`PORT5_PAGE_BIT]};
      `ADDR_PORT6: rd_mux = (PORT6_DIR & PORT6_IN) | (~PORT6_DIR & port6_reg);
      default:
      begin
        if (in_common)
          rd_mux = common_mem[eff_addr[3:0]];
        else if (in_banked)
          rd_mux = banked_mem[bank_index];
        else
          rd_mux = `ZERO8; // Unmapped reads zero
      end
    endcase
  end

  // Program counter next value
  always_comb
  begin
    pc_next = pc_reg;
    case (REQ.op)
      OP_STEP: pc_next = pc_inc;
      OP_JUMP: pc_next = pc_page_base | {2'b00, REQ.target};
      OP_CALL: pc_next = pc_page_base | {2'b00, REQ.target};
      OP_RET: pc_next = stack_top;
      OP_ADDPC: pc_next = pc_reg + {4'h0, REQ.wdata};
      OP_WRITE:
      begin
        if (eff_addr == `ADDR_PC)
          pc_next = {status_reg[`ST_PAGE_HI:`ST_PAGE_LO], pc_reg[9:8], REQ.wdata};
        else
          pc_next = pc_inc;
      end
      default: pc_next = pc_reg;
    endcase
  end

  // Status next value: writes, then commands, then ALU flags, then causes
  always_comb
  begin
    status_next = status_reg;
    if (is_wr && eff_addr == `ADDR_STATUS)
      status_next = REQ.wdata & `STATUS_MASK;
    if (REQ.op == OP_PAGE)
      status_next[`ST_PAGE_HI:`ST_PAGE_LO] = REQ.sel;
    if (REQ.op == OP_SLEEP)
    begin
      status_next[`ST_TIMEOUT] = 1'b1;
      status_next[`ST_PWRDN] = 1'b0;
    end
    if (REQ.op == OP_WDCLR)
    begin
      status_next[`ST_TIMEOUT] = 1'b1;
      status_next[`ST_PWRDN] = 1'b1;
    end
    if (REQ.flags_we)
      status_next[`ST_ZERO:`ST_CARRY] = REQ.flags;
    // Cause events win the time-out and power-down bits over every other source in the same cycle
    if (EVENT_STB)
      status_next[`ST_TIMEOUT:`ST_PWRDN] = EVENT_KIND;
  end

  // Other register next values
  always_comb
  begin
    bptr_next = bptr_reg;
    port5_next = port5_reg;
    port6_next = port6_reg;
    timer_next = timer_tick ? timer_reg + 8'h01 : timer_reg;
    if (is_wr)
    begin
      case (eff_addr)
        `ADDR_TIMER: timer_next = REQ.wdata; // Write wins over tick
        `ADDR_BANKPTR: bptr_next = REQ.wdata;
        `ADDR_PORT5: port5_next = REQ.wdata & `PORT5_MASK;
        `ADDR_PORT6: port6_next = REQ.wdata;
        default: bptr_next = bptr_reg;
      endcase
    end
    if (REQ.op == OP_BANK)
      bptr_next[`BANK_HI:`BANK_LO] = REQ.sel;
  end

  // Timer pin synchroniser; the second and third stages feed the edge detector
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      {pin_s1, pin_s2, pin_s3} <= 3'b000;
    else
      {pin_s1, pin_s2, pin_s3} <= {TIMER_PIN, pin_s1, pin_s2};
  end

  // Register update; reset is power-up, so both flags set
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pc_reg <= `PC_RESET;
      status_reg <= `STATUS_RESET;
      timer_reg <= `ZERO8;
      bptr_reg <= `ZERO8;
      port5_reg <= `ZERO8;
      port6_reg <= `ZERO8;
    end
    else
    begin
      pc_reg <= pc_next;
      status_reg <= status_next;
      timer_reg <= timer_next;
      bptr_reg <= bptr_next;
      port5_reg <= port5_next;
      port6_reg <= port6_next;
    end
  end

  // Stack pointer: call pushes, return pops, wraps like a ring
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      sp_reg <= 3'd0;
    else if (REQ.op == OP_CALL)
      sp_reg <= sp_reg + 3'd1;
    else if (REQ.op == OP_RET)
      sp_reg <= sp_reg - 3'd1;
  end

  // Stack storage holds the address after the call
  always_ff @(posedge CLK)
  begin
    if (REQ.op == OP_CALL)
      stack_mem[sp_reg] <= pc_inc;
  end

  // General data memory writes
  always_ff @(posedge CLK)
  begin
    if (is_wr && in_common)
      common_mem[eff_addr[3:0]] <= REQ.wdata;
    if (is_wr && in_banked)
      banked_mem[bank_index] <= REQ.wdata;
  end

  // Registered outputs
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      rdata_reg <= `ZERO8;
    else
      rdata_reg <= rd_mux;
  end
  assign RDATA = rdata_reg;
  assign PC_OUT = pc_reg;
  assign STATUS_OUT = status_reg;
  assign BANK_OUT = bptr_reg[`BANK_HI:`BANK_LO];
  assign CTRL_PAGE = port5_reg[`PORT5_PAGE_BIT];
  assign PORT5_OUT = port5_reg[7:4];
  assign PORT6_OUT = port6_reg;

  // Checks
  sequence s_call_now;
    REQ.op == OP_CALL;
  endsequence
  sequence s_ret_next;
    ##1 REQ.op == OP_RET;
  endsequence
  chk_pc_reset_zero: assert property (@(posedge CLK) $rose(RSTN) |-> pc_reg == `PC_RESET)
    else $error("pc not zero after reset");
  chk_jump_target: assert property (@(posedge CLK) disable iff (!RSTN)
    REQ.op == OP_JUMP |=> pc_reg[9:0] == $past(REQ.target))
    else $error("jump target wrong");
  chk_jump_page: assert property (@(posedge CLK) disable iff (!RSTN)
    REQ.op == OP_JUMP |=> pc_reg[11:10] == $past(status_reg[`ST_PAGE_HI:`ST_PAGE_LO]))
    else $error("jump page wrong");
  chk_call_return: assert property (@(posedge CLK) disable iff (!RSTN)
    (s_call_now ##0 s_ret_next) |=> pc_reg == $past(pc_reg, 2) + 12'h001)
    else $error("return address wrong");
  chk_mov_pc_keep: assert property (@(posedge CLK) disable iff (!RSTN)
    (is_wr && eff_addr == `ADDR_PC) |=> pc_reg[9:8] == $past(pc_reg[9:8])
      && pc_reg[7:0] == $past(REQ.wdata))
    else $error("move to pc wrong");
  chk_add_pc: assert property (@(posedge CLK) disable iff (!RSTN)
    REQ.op == OP_ADDPC |=> pc_reg == $past(pc_reg) + {4'h0, $past(REQ.wdata)})
    else $error("add to pc wrong");
  chk_sleep_flags: assert property (@(posedge CLK) disable iff (!RSTN)
    (REQ.op == OP_SLEEP && !EVENT_STB) |=> status_reg[`ST_TIMEOUT:`ST_PWRDN] == 2'b10)
    else $error("sleep flags wrong");
  chk_cause_flags: assert property (@(posedge CLK) disable iff (!RSTN)
    EVENT_STB |=> status_reg[`ST_TIMEOUT:`ST_PWRDN] == $past(EVENT_KIND))
    else $error("cause flags wrong");
  chk_indirect_read: assert property (@(posedge CLK) disable iff (!RSTN)
    (REQ.addr == `ADDR_INDIRECT && bptr_reg[5:0] == 6'h04) |-> rd_mux == bptr_reg)
    else $error("indirect read wrong");
  chk_reserved_zero: assert property (@(posedge CLK) disable iff (!RSTN)
    STATUS_OUT[7] == 1'b0 && port5_reg[3:1] == 3'b000)
    else $error("reserved bit set");
endmodule

// *** test_core_sfr.sv ***
// Self-checking testbench for the core special register group
`timescale 1ns/1ns
module test_core_sfr import core_sfr_pkg::*;;
  logic CLK, RSTN, TIMER_PIN, TIMER_SRC_PIN, CYCLE_EN, EVENT_STB; // Scalar inputs
  sfr_req_t REQ; // Request from the instruction stream
  sfr_event_t EVENT_KIND; // Wake or reset cause
  logic [3:0] PORT5_IN, PORT5_DIR, PORT5_OUT; // Port 5 pins, direction, latch
  logic [7:0] PORT6_IN, PORT6_DIR, PORT6_OUT; // Port 6 pins, direction, latch
  logic [7:0] RDATA, STATUS_OUT; // Read data and status copy
  logic [11:0] PC_OUT; // Program ROM address
  logic [1:0] BANK_OUT; // Active data bank
  logic CTRL_PAGE; // Control register page
  int fail_count, samples_checked; // Mismatch and comparison counters

  // Device under test
  core_sfr core_sfr_inst (.CLK(CLK), .RSTN(RSTN), .REQ(REQ), .TIMER_PIN(TIMER_PIN),
    .TIMER_SRC_PIN(TIMER_SRC_PIN), .CYCLE_EN(CYCLE_EN), .EVENT_STB(EVENT_STB),
    .EVENT_KIND(EVENT_KIND), .PORT5_IN(PORT5_IN), .PORT6_IN(PORT6_IN),
    .PORT5_DIR(PORT5_DIR), .PORT6_DIR(PORT6_DIR), .RDATA(RDATA), .PC_OUT(PC_OUT),
    .STATUS_OUT(STATUS_OUT), .BANK_OUT(BANK_OUT), .CTRL_PAGE(CTRL_PAGE),
    .PORT5_OUT(PORT5_OUT), .PORT6_OUT(PORT6_OUT));

  // Clock at 100 MHz
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Prints counts and verdict, then stops
  task automatic end_sim;
    $display("checked=%0d errors=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Compares one register value
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One request for one cycle, then an idle cycle
  task automatic go(input sfr_op_t o, input logic [7:0] a, input logic [7:0] d,
    input logic [9:0] t = 10'h000, input logic [1:0] s = 2'h0,
    input logic fw = 1'b0, input logic [2:0] fl = 3'h0);
    REQ = '{op: o, addr: a, wdata: d, target: t, sel: s, flags_we: fw, flags: fl};
    @(negedge CLK);
    REQ.op = OP_NONE;
    REQ.flags_we = 1'b0;
    @(negedge CLK);
  endtask

  // Reads one address and compares the registered read data
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    REQ.op = OP_STEP;
    REQ.addr = a;
    @(negedge CLK);
    cmp({4'h0, RDATA}, {4'h0, e});
    REQ.op = OP_NONE;
    @(negedge CLK);
  endtask

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge CLK);
    fail_count++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    RSTN = 1'b0;
    REQ = '{op: OP_NONE, addr: 8'h00, wdata: 8'h00, target: 10'h000, sel: 2'h0,
      flags_we: 1'b0, flags: 3'h0};
    {TIMER_PIN, TIMER_SRC_PIN, CYCLE_EN, EVENT_STB} = 4'h0;
    EVENT_KIND = EV_WDT_WAKE;
    {PORT5_IN, PORT5_DIR, PORT6_IN, PORT6_DIR} = 24'h00_0000;
    fail_count = 0;
    samples_checked = 0;
    repeat (6) @(negedge CLK);
    RSTN = 1'b1;
    cmp(PC_OUT, 12'h000);
    cmp({4'h0, STATUS_OUT}, 12'h018);
    // Paged jump, call from page 1, return after a page change
    go(OP_PAGE, 8'h00, 8'h00, 10'h000, 2'h1);
    cmp({4'h0, STATUS_OUT}, 12'h038);
    go(OP_JUMP, 8'h00, 8'h00, 10'h005);
    cmp(PC_OUT, 12'h405);
    go(OP_CALL, 8'h00, 8'h00, 10'h3FF);
    cmp(PC_OUT, 12'h7FF);
    go(OP_PAGE, 8'h00, 8'h00, 10'h000, 2'h2);
    go(OP_RET, 8'h00, 8'h00);
    cmp(PC_OUT, 12'h406);
    cmp({4'h0, STATUS_OUT}, 12'h058);
    // Relative add carrying into bit 8, then move to the low byte
    go(OP_PAGE, 8'h00, 8'h00, 10'h000, 2'h0);
    go(OP_JUMP, 8'h00, 8'h00, 10'h0F0);
    go(OP_ADDPC, 8'h02, 8'h20);
    cmp(PC_OUT, 12'h110);
    go(OP_WRITE, 8'h02, 8'h34);
    cmp(PC_OUT, 12'h134);
    go(OP_PAGE, 8'h00, 8'h00, 10'h000, 2'h3);
    go(OP_WRITE, 8'h02, 8'h56);
    cmp(PC_OUT, 12'hD56);
    // Call and return on back-to-back cycles
    REQ = '{op: OP_CALL, addr: 8'h00, wdata: 8'h00, target: 10'h010, sel: 2'h0,
      flags_we: 1'b0, flags: 3'h0};
    @(negedge CLK);
    REQ.op = OP_RET;
    @(negedge CLK);
    REQ.op = OP_NONE;
    @(negedge CLK);
    cmp(PC_OUT, 12'hD57);
    // Time-out and power-down flags
    go(OP_SLEEP, 8'h00, 8'h00);
    cmp({4'h0, STATUS_OUT}, 12'h070);
    go(OP_WDCLR, 8'h00, 8'h00);
    cmp({4'h0, STATUS_OUT}, 12'h078);
    for (int k = 0; k < 4; k++)
    begin
      EVENT_KIND = sfr_event_t'(k);
      EVENT_STB = 1'b1;
      @(negedge CLK);
      EVENT_STB = 1'b0;
      @(negedge CLK);
      cmp({4'h0, STATUS_OUT}, 12'h060 | 12'(k << 3));
    end
    go(OP_STEP, 8'h00, 8'h00, 10'h000, 2'h0, 1'b1, 3'h5);
    cmp({4'h0, STATUS_OUT}, 12'h07D);
    go(OP_WRITE, 8'h03, 8'hFF);
    rd(8'h03, 8'h7F);
    go(OP_WRITE, 8'h03, 8'h00);
    // Bank pointer, indirect window, common and banked bytes
    go(OP_WRITE, 8'h04, 8'hC5);
    cmp({10'h000, BANK_OUT}, 12'h003);
    go(OP_BANK, 8'h00, 8'h00, 10'h000, 2'h1);
    rd(8'h04, 8'h45);
    go(OP_WRITE, 8'h04, 8'h12);
    go(OP_WRITE, 8'h00, 8'hA5);
    rd(8'h12, 8'hA5);
    rd(8'h00, 8'hA5);
    go(OP_WRITE, 8'h04, 8'hA5);
    go(OP_WRITE, 8'h25, 8'h5A);
    go(OP_WRITE, 8'h1F, 8'h77);
    go(OP_BANK, 8'h00, 8'h00, 10'h000, 2'h0);
    go(OP_WRITE, 8'h25, 8'h11);
    rd(8'h25, 8'h11);
    rd(8'h1F, 8'h77);
    go(OP_BANK, 8'h00, 8'h00, 10'h000, 2'h2);
    rd(8'h25, 8'h5A);
    rd(8'h00, 8'h5A);
    // Pointer aimed at itself through the window
    go(OP_WRITE, 8'h04, 8'h44);
    rd(8'h00, 8'h44);
    // Timer: write, cycle ticks, then pin edges
    go(OP_WRITE, 8'h01, 8'hF0);
    rd(8'h01, 8'hF0);
    repeat (3)
    begin
      CYCLE_EN = 1'b1;
      @(negedge CLK);
      CYCLE_EN = 1'b0;
      @(negedge CLK);
    end
    rd(8'h01, 8'hF3);
    TIMER_SRC_PIN = 1'b1;
    repeat (2)
    begin
      TIMER_PIN = 1'b1;
      repeat (4) @(negedge CLK);
      TIMER_PIN = 1'b0;
      repeat (4) @(negedge CLK);
    end
    rd(8'h01, 8'hF5);
    // Ports, control page bit, unmapped address
    go(OP_WRITE, 8'h05, 8'hFF);
    cmp({7'h00, CTRL_PAGE, PORT5_OUT}, 12'h01F);
    rd(8'h05, 8'hF1);
    PORT5_DIR = 4'hF;
    PORT5_IN = 4'hA;
    rd(8'h05, 8'hA1);
    go(OP_WRITE, 8'h06, 8'h3C);
    cmp({4'h0, PORT6_OUT}, 12'h03C);
    PORT6_DIR = 8'hF0;
    PORT6_IN = 8'hA5;
    rd(8'h06, 8'hAC);
    go(OP_WRITE, 8'h08, 8'h55);
    rd(8'h08, 8'h00);
    // Reset in mid-run
    RSTN = 1'b0;
    @(negedge CLK);
    cmp(PC_OUT, 12'h000);
    cmp({4'h0, STATUS_OUT}, 12'h018);
    RSTN = 1'b1;
    rd(8'h02, 8'h00);
    cmp(PC_OUT, 12'h001);
    @(negedge CLK);
    end_sim();
  end
endmodule
